// ---- pfg_port_f_g_io_mux.sv ----
// Port F and port G pin block with AHB-Lite register slave.
// Assumes one clock, pins synchronous to it and a single bus master.
//
// The implementer's own choice: the AHB-Lite interface to the registers.

module pfg_port_f_g_io_mux #(
	parameter int WIDTH = pfg_pkg::PFG_WIDTH
) (
	input  wire logic                 clock,
	input  wire logic                 resetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic [31:0]               hrdata,
	output logic                      hresp,
	// Pads
	input  wire logic [WIDTH-1:0]     port_f_pin_in,
	output pfg_pkg::pfg_pins_type     port_f_pins,
	input  wire logic [WIDTH-1:0]     port_g_pin_in,
	output pfg_pkg::pfg_pins_type     port_g_pins,
	// Serial bus unit
	input  wire logic                 serial_bus_data_out,
	input  wire logic                 serial_bus_in_out,
	input  wire logic                 serial_bus_clock_out,
	output logic                      serial_bus_data_in,
	output logic                      serial_bus_in,
	output logic                      serial_bus_clock_in,
	// DMA controller and the competing port J
	output logic                      dma_request_ch2,
	output logic                      dma_request_ch3,
	input  wire logic                 dma_acknowledge_ch2,
	input  wire logic                 dma_acknowledge_ch3,
	input  wire logic [1:0]           port_j_dma_select,
	input  wire logic [1:0]           port_j_dma_request,
	output logic [1:0]                port_j_dma_acknowledge,
	// 32-bit timer unit
	output logic                      timebase_external_clock,
	output logic [3:0]                capture_trigger,
	input  wire logic [3:0]           compare_output
);

	import pfg_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	pfg_port_type           port_f;
	pfg_port_type           port_g;
	logic [WIDTH-1:0]       port_f_drive_type;
	pfg_phase_type          phase;
	logic [PFG_DEC_BITS-1:0] data_idx;

	logic [WIDTH-1:0]       f_alt_out;
	logic [WIDTH-1:0]       f_alt_in;
	logic [WIDTH-1:0]       g_alt_out;
	logic [WIDTH-1:0]       g_alt_in;
	logic [WIDTH-1:0]       f_open_drain;
	logic [WIDTH-1:0]       f_pin_out;
	logic [WIDTH-1:0]       f_pin_oe;
	logic [WIDTH-1:0]       g_pin_out;
	logic [WIDTH-1:0]       g_pin_oe;

	logic                   addr_accept;
	logic [PFG_DEC_BITS-1:0] addr_idx;
	logic [WIDTH-1:0]       next_read;
	logic [WIDTH-1:0]       f_view;
	logic [WIDTH-1:0]       g_view;
	logic                   wr_now;

	// ----------------------------------------------------------------
	// Bus address phase
	// ----------------------------------------------------------------
	// Whole-word accesses only; index sits above the byte offset bits
	assign addr_accept = hsel & hready & (htrans == PFG_HTRANS_NONSEQ);
	assign addr_idx    = haddr[PFG_DEC_BITS+1:2];
	assign hreadyout   = 1'b1;
	assign hresp       = PFG_HRESP_OKAY;
	assign wr_now      = (phase == PFG_PHASE_WRITE);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phase    <= PFG_PHASE_IDLE;
			data_idx <= '0;
		end else if (hready) begin
			if (addr_accept) begin
				phase    <= hwrite ? PFG_PHASE_WRITE : PFG_PHASE_READ;
				data_idx <= addr_idx;
			end else begin
				phase <= PFG_PHASE_IDLE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Input bits show the pad, output bits the latch
	assign f_view = (port_f_pin_in & ~port_f.dir) | (port_f.latch & port_f.dir);
	assign g_view = (port_g_pin_in & ~port_g.dir) | (port_g.latch & port_g.dir);

	always_comb begin
		case (addr_idx)
			PFG_IDX_F_DATA[PFG_DEC_BITS-1:0]:  next_read = f_view;
			PFG_IDX_G_DATA[PFG_DEC_BITS-1:0]:  next_read = g_view;
			PFG_IDX_F_DIR[PFG_DEC_BITS-1:0]:   next_read = port_f.dir;
			PFG_IDX_G_DIR[PFG_DEC_BITS-1:0]:   next_read = port_g.dir;
			PFG_IDX_F_FUNC[PFG_DEC_BITS-1:0]:  next_read = port_f.func;
			PFG_IDX_G_FUNC[PFG_DEC_BITS-1:0]:  next_read = port_g.func;
			PFG_IDX_F_DRIVE[PFG_DEC_BITS-1:0]: next_read = port_f_drive_type & PFG_F_DRIVE_MASK;
			default:                           next_read = '0;
		endcase
	end

	// Sampled in the address phase, so a read right behind a write sees the old value
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hrdata <= '0;
		end else if (addr_accept && !hwrite) begin
			hrdata <= {{(32-WIDTH){1'b0}}, next_read};
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			port_f.latch <= PFG_LATCH_RST;
			port_g.latch <= PFG_LATCH_RST;
		end else if (wr_now) begin
			// Latch loads whatever the direction
			if (data_idx == PFG_IDX_F_DATA[PFG_DEC_BITS-1:0]) begin
				port_f.latch <= hwdata[WIDTH-1:0];
			end
			if (data_idx == PFG_IDX_G_DATA[PFG_DEC_BITS-1:0]) begin
				port_g.latch <= hwdata[WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			port_f.dir  <= PFG_CTRL_RST;
			port_f.func <= PFG_CTRL_RST;
			port_g.dir  <= PFG_CTRL_RST;
			port_g.func <= PFG_CTRL_RST;
		end else if (wr_now) begin
			if (data_idx == PFG_IDX_F_DIR[PFG_DEC_BITS-1:0]) begin
				port_f.dir <= hwdata[WIDTH-1:0];
			end
			if (data_idx == PFG_IDX_G_DIR[PFG_DEC_BITS-1:0]) begin
				port_g.dir <= hwdata[WIDTH-1:0];
			end
			if (data_idx == PFG_IDX_F_FUNC[PFG_DEC_BITS-1:0]) begin
				port_f.func <= hwdata[WIDTH-1:0];
			end
			if (data_idx == PFG_IDX_G_FUNC[PFG_DEC_BITS-1:0]) begin
				port_g.func <= hwdata[WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			port_f_drive_type <= PFG_CTRL_RST;
		end else if (wr_now && data_idx == PFG_IDX_F_DRIVE[PFG_DEC_BITS-1:0]) begin
			// Only bits 0 and 1 hold; the rest stay zero
			port_f_drive_type <= hwdata[WIDTH-1:0] & PFG_F_DRIVE_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Alternate function routing
	// ----------------------------------------------------------------
	always_comb begin
		f_alt_out                 = '0;
		f_alt_out[PFG_F_SB_DATA]  = serial_bus_data_out;
		f_alt_out[PFG_F_SB_IN]    = serial_bus_in_out;
		f_alt_out[PFG_F_SB_CLOCK] = serial_bus_clock_out;
		f_alt_out[PFG_F_DMA_ACKNOWLEDGE_CH2]    = dma_acknowledge_ch2;
		f_alt_out[PFG_F_DMA_ACKNOWLEDGE_CH3]    = dma_acknowledge_ch3;
	end

	assign serial_bus_data_in      = f_alt_in[PFG_F_SB_DATA];
	assign serial_bus_in           = f_alt_in[PFG_F_SB_IN];
	assign serial_bus_clock_in     = f_alt_in[PFG_F_SB_CLOCK];
	assign timebase_external_clock = f_alt_in[PFG_F_TIMEBASE];

	// Port F claims a channel first; port J is heard only when F leaves it
	assign dma_request_ch2 = port_f.func[PFG_F_DMA_REQUEST_CH2] ? f_alt_in[PFG_F_DMA_REQUEST_CH2]
		: (port_j_dma_select[0] & port_j_dma_request[0]);
	assign dma_request_ch3 = port_f.func[PFG_F_DMA_REQUEST_CH3] ? f_alt_in[PFG_F_DMA_REQUEST_CH3]
		: (port_j_dma_select[1] & port_j_dma_request[1]);
	assign port_j_dma_acknowledge[0] = port_j_dma_select[0] & ~port_f.func[PFG_F_DMA_ACKNOWLEDGE_CH2]
		& dma_acknowledge_ch2;
	assign port_j_dma_acknowledge[1] = port_j_dma_select[1] & ~port_f.func[PFG_F_DMA_ACKNOWLEDGE_CH3]
		& dma_acknowledge_ch3;

	assign g_alt_out = {compare_output, {PFG_G_GROUP{1'b0}}};
	assign capture_trigger = g_alt_in[PFG_G_CAPTURE_LO +: PFG_G_GROUP];

	assign f_open_drain = port_f_drive_type & PFG_F_DRIVE_MASK;

	// ----------------------------------------------------------------
	// Pin cells
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_pins
		pfg_pin_cell u_f (
			.dir        (port_f.dir[i]),
			.func       (port_f.func[i]),
			.latch      (port_f.latch[i]),
			.alt_out    (f_alt_out[i]),
			.open_drain (f_open_drain[i]),
			.pin_in     (port_f_pin_in[i]),
			.pin_out    (f_pin_out[i]),
			.pin_oe     (f_pin_oe[i]),
			.alt_in     (f_alt_in[i])
		);
		pfg_pin_cell u_g (
			.dir        (port_g.dir[i]),
			.func       (port_g.func[i]),
			.latch      (port_g.latch[i]),
			.alt_out    (g_alt_out[i]),
			.open_drain (1'b0),
			.pin_in     (port_g_pin_in[i]),
			.pin_out    (g_pin_out[i]),
			.pin_oe     (g_pin_oe[i]),
			.alt_in     (g_alt_in[i])
		);
	end

	assign port_f_pins.value  = f_pin_out;
	assign port_f_pins.enable = f_pin_oe;
	assign port_g_pins.value  = g_pin_out;
	assign port_g_pins.enable = g_pin_oe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	logic after_reset;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			after_reset <= 1'b1;
		end else begin
			after_reset <= 1'b0;
		end
	end

	AST_RESET_STATE: assert property (
		after_reset |-> (port_f.dir == PFG_CTRL_RST) && (port_f.func == PFG_CTRL_RST)
			&& (port_g.dir == PFG_CTRL_RST) && (port_g.func == PFG_CTRL_RST)
			&& (port_f.latch == PFG_LATCH_RST) && (port_g.latch == PFG_LATCH_RST)
			&& (port_f_pins.enable == '0) && (port_g_pins.enable == '0))
		else $error("state after reset wrong");

	AST_F_INPUT_FLOAT: assert property (
		(port_f_pins.enable & ~port_f.dir) == '0)
		else $error("port F drives an input pin");

	AST_G_PLAIN_OUT: assert property (
		((port_g_pins.value ^ port_g.latch) & port_g.dir & ~port_g.func) == '0
			&& ((port_g_pins.enable ^ port_g.dir) == '0))
		else $error("port G plain output wrong");

	AST_F_SB_CLOCK: assert property (
		(port_f.func[PFG_F_SB_CLOCK] && port_f.dir[PFG_F_SB_CLOCK])
			|-> port_f_pins.value[PFG_F_SB_CLOCK] == serial_bus_clock_out)
		else $error("serial clock not on pin");

	AST_F_TIMEBASE: assert property (
		timebase_external_clock == (port_f.func[PFG_F_TIMEBASE] & port_f_pin_in[PFG_F_TIMEBASE]))
		else $error("time-base clock routing wrong");

	AST_DMA_PRIORITY: assert property (
		(port_f.func[PFG_F_DMA_REQUEST_CH2] && port_j_dma_select[0])
			|-> dma_request_ch2 == port_f_pin_in[PFG_F_DMA_REQUEST_CH2] && !port_j_dma_acknowledge[0])
		else $error("port J not overridden on channel 2");

	AST_DRIVE_READ: assert property (
		(addr_accept && !hwrite && addr_idx == PFG_IDX_F_DRIVE[PFG_DEC_BITS-1:0])
			|=> hrdata[WIDTH-1:2] == '0 && hrdata[1:0] == $past(port_f_drive_type[1:0]))
		else $error("drive type read wrong");

	AST_OPEN_DRAIN: assert property (
		(port_f.dir[0] && f_open_drain[0])
			|-> !port_f_pins.value[0] && (port_f_pins.enable[0] != f_pin_cell_value0()))
		else $error("open drain bit 0 wrong");

	AST_G_CAPTURE: assert property (
		port_g.func[PFG_G_CAPTURE_LO] |-> capture_trigger[0] == port_g_pin_in[PFG_G_CAPTURE_LO])
		else $error("capture trigger 0 not routed");

	AST_G_COMPARE: assert property (
		(port_g.func[PFG_G_COMPARE_LO] && port_g.dir[PFG_G_COMPARE_LO])
			|-> port_g_pins.enable[PFG_G_COMPARE_LO]
			&& port_g_pins.value[PFG_G_COMPARE_LO] == compare_output[0])
		else $error("compare output 0 not on pin");

	AST_DATA_WRITE: assert property (
		(wr_now && data_idx == PFG_IDX_F_DATA[PFG_DEC_BITS-1:0])
			|=> port_f.latch == $past(hwdata[WIDTH-1:0]))
		else $error("port F latch not loaded");

	AST_DATA_READ: assert property (
		(addr_accept && !hwrite && addr_idx == PFG_IDX_G_DATA[PFG_DEC_BITS-1:0])
			|=> hrdata[WIDTH-1:0] == $past((port_g_pin_in & ~port_g.dir) | (port_g.latch & port_g.dir)))
		else $error("port G data read wrong");

	function automatic logic f_pin_cell_value0();
		f_pin_cell_value0 = port_f.func[0] ? serial_bus_data_out : port_f.latch[0];
	endfunction

endmodule

// ---- pfg_pkg.sv ----
// Constants, register map and carrier types of the port F / port G pin block.
// Assumes a single-slave AHB-Lite segment with 32-bit data and one clock.

package pfg_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PFG_WIDTH    = 8;
	localparam int PFG_DEC_BITS = 8;

	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [31:0] PFG_IDX_F_DATA  = 32'hFFFF_F060;
	localparam logic [31:0] PFG_IDX_G_DATA  = 32'hFFFF_F061;
	localparam logic [31:0] PFG_IDX_F_DIR   = 32'hFFFF_F064;
	localparam logic [31:0] PFG_IDX_G_DIR   = 32'hFFFF_F065;
	localparam logic [31:0] PFG_IDX_F_FUNC  = 32'hFFFF_F068;
	localparam logic [31:0] PFG_IDX_G_FUNC  = 32'hFFFF_F069;
	localparam logic [31:0] PFG_IDX_F_DRIVE = 32'hFFFF_F06C;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] PFG_LATCH_RST    = 8'hFF;
	localparam logic [7:0] PFG_CTRL_RST     = 8'h00;
	localparam logic [7:0] PFG_F_DRIVE_MASK = 8'h03;

	// ----------------------------------------------------------------
	// Port F alternate function bit positions
	// ----------------------------------------------------------------
	localparam int PFG_F_SB_DATA  = 0;
	localparam int PFG_F_SB_IN    = 1;
	localparam int PFG_F_SB_CLOCK = 2;
	localparam int PFG_F_DMA_REQUEST_CH2    = 3;
	localparam int PFG_F_DMA_ACKNOWLEDGE_CH2    = 4;
	localparam int PFG_F_DMA_REQUEST_CH3    = 5;
	localparam int PFG_F_DMA_ACKNOWLEDGE_CH3    = 6;
	localparam int PFG_F_TIMEBASE = 7;

	// ----------------------------------------------------------------
	// Port G alternate function groups
	// ----------------------------------------------------------------
	localparam int PFG_G_CAPTURE_LO = 0;
	localparam int PFG_G_COMPARE_LO = 4;
	localparam int PFG_G_GROUP      = 4;

	// ----------------------------------------------------------------
	// AHB-Lite codes
	// ----------------------------------------------------------------
	localparam logic [1:0] PFG_HTRANS_NONSEQ = 2'h2;
	localparam logic       PFG_HRESP_OKAY    = 1'b0;

	typedef enum logic [1:0] {
		PFG_PHASE_IDLE,
		PFG_PHASE_WRITE,
		PFG_PHASE_READ
	} pfg_phase_type;

	typedef struct packed {
		logic [PFG_WIDTH-1:0] latch;
		logic [PFG_WIDTH-1:0] dir;
		logic [PFG_WIDTH-1:0] func;
	} pfg_port_type;

	typedef struct packed {
		logic [PFG_WIDTH-1:0] value;
		logic [PFG_WIDTH-1:0] enable;
	} pfg_pins_type;

endpackage

// ---- pfg_pin_cell.sv ----
// One pin of a general-purpose port: output mux, drive type, alternate input.
// Assumes the pad resolves its level from value and enable outside.

module pfg_pin_cell (
	input  wire logic dir,
	input  wire logic func,
	input  wire logic latch,
	input  wire logic alt_out,
	input  wire logic open_drain,
	input  wire logic pin_in,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      alt_in
);

	logic drive_value;

	// Peripheral owns the pin only while its select bit is set
	assign drive_value = func ? alt_out : latch;

	always_comb begin
		pin_out = drive_value;
		pin_oe  = 1'b0;
		if (dir) begin
			if (open_drain) begin
				// Low is driven, high is released to the pull-up
				pin_out = 1'b0;
				pin_oe  = ~drive_value;
			end else begin
				pin_oe = 1'b1;
			end
		end
	end

	// Gated so an idle peripheral never sees a stray pin edge
	assign alt_in = func & pin_in;

endmodule

// ---- pfg_board_model.sv ----
// Board model for the port F and port G pads: resolves each pad level.
// Assumes the bench sets what the board drives and the device pad bus is live.

module pfg_board_model (
	input  wire logic                  clock,
	input  wire pfg_pkg::pfg_pins_type f_pins,
	input  wire pfg_pkg::pfg_pins_type g_pins,
	input  wire logic [7:0]            f_drive_val,
	input  wire logic [7:0]            f_drive_en,
	input  wire logic [7:0]            g_drive_val,
	input  wire logic [7:0]            g_drive_en,
	output logic [7:0]                 f_level,
	output logic [7:0]                 g_level
);
	import pfg_pkg::*;

	// ----------------------------------------------------------------
	// Pad resolution
	// ----------------------------------------------------------------
	logic [7:0] float_pattern;

	// Floating lines toggle each cycle, except the pulled-up port F bits 0 and 1, so a stale level never reads as valid
	initial float_pattern = 8'h55;
	always @(posedge clock) begin
		float_pattern <= ~float_pattern;
	end

	// Port F bits 0 and 1 carry board pull-ups for open-drain use; port G has none
	assign f_level = (f_pins.enable & f_pins.value) | (~f_pins.enable & f_drive_en & f_drive_val)
		| (~f_pins.enable & ~f_drive_en & (float_pattern | 8'h03));
	assign g_level = (g_pins.enable & g_pins.value) | (~g_pins.enable & g_drive_en & g_drive_val)
		| (~g_pins.enable & ~g_drive_en & float_pattern);
endmodule

// ---- test_pfg_port_f_g_io_mux.sv ----
// Self-checking bench for the port F / port G pin block.
// Assumes the board model beside it and an AHB-Lite master in the tasks.

module test_pfg_port_f_g_io_mux;
	timeunit 1ns;
	timeprecision 1ns;
	import pfg_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic          clock, resetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]   haddr, hwdata, hrdata;
	logic [1:0]    htrans, pj_sel, pj_req, pj_ack;
	logic [2:0]    hsize;
	logic [7:0]    f_level, g_level, bf_val, bf_en, bg_val, bg_en;
	logic          sb_do, sb_io, sb_ck, sb_di, sb_in, sb_ci;
	logic          ack2, ack3, req2, req3, tbclk;
	logic [3:0]    capture, cmp;
	pfg_pins_type  f_pins, g_pins;
	int            n_mismatch, checks_done;

	pfg_port_f_g_io_mux #(.WIDTH(8)) pfg_port_f_g_io_mux_inst (
		.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.port_f_pin_in(f_level), .port_f_pins(f_pins), .port_g_pin_in(g_level), .port_g_pins(g_pins),
		.serial_bus_data_out(sb_do), .serial_bus_in_out(sb_io), .serial_bus_clock_out(sb_ck),
		.serial_bus_data_in(sb_di), .serial_bus_in(sb_in), .serial_bus_clock_in(sb_ci),
		.dma_request_ch2(req2), .dma_request_ch3(req3), .dma_acknowledge_ch2(ack2),
		.dma_acknowledge_ch3(ack3), .port_j_dma_select(pj_sel), .port_j_dma_request(pj_req),
		.port_j_dma_acknowledge(pj_ack), .timebase_external_clock(tbclk),
		.capture_trigger(capture), .compare_output(cmp));

	pfg_board_model pfg_board_model_inst (
		.clock(clock), .f_pins(f_pins), .g_pins(g_pins), .f_drive_val(bf_val), .f_drive_en(bf_en),
		.g_drive_val(bg_val), .g_drive_en(bg_en), .f_level(f_level), .g_level(g_level));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One single word transfer; the watchdog ends a wait that never closes
	task automatic bus(input logic wr, input logic [31:0] idx, input logic [7:0] wdata,
		output logic [31:0] rdata);
		@(posedge clock);
		hsel   <= 1'b1;
		haddr  <= {idx[29:0], 2'b00};
		htrans <= PFG_HTRANS_NONSEQ;
		hwrite <= wr;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= {24'h0, wdata};
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rdata = hrdata;
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] idx, input logic [7:0] data);
		logic [31:0] unused;
		bus(1'b1, idx, data, unused);
	endtask

	task automatic rd_chk(input string name, input logic [31:0] idx, input logic [7:0] exp);
		logic [31:0] data;
		bus(1'b0, idx, 8'h00, data);
		check(name, data, {24'h0, exp});
	endtask

	task automatic settle;
		@(posedge clock);
		#1;
	endtask

	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Tests take well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		complete_run;
	end

	initial begin
		resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
		hwdata = 32'h0; sb_do = 1'b1; sb_io = 1'b0; sb_ck = 1'b0; ack2 = 1'b1; ack3 = 1'b0;
		pj_sel = 2'h3; pj_req = 2'h0; cmp = 4'h6;
		bf_val = 8'h5A; bf_en = 8'hFF; bg_val = 8'hA5; bg_en = 8'hFF;
		n_mismatch = 0; checks_done = 0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		settle;
		check("f enable", 32'(f_pins.enable), 32'h0);
		check("g enable", 32'(g_pins.enable), 32'h0);
		rd_chk("f data", PFG_IDX_F_DATA, 8'h5A);
		rd_chk("g data", PFG_IDX_G_DATA, 8'hA5);
		rd_chk("f dir", PFG_IDX_F_DIR, 8'h00);
		rd_chk("f func", PFG_IDX_F_FUNC, 8'h00);
		rd_chk("g dir", PFG_IDX_G_DIR, 8'h00);
		rd_chk("g func", PFG_IDX_G_FUNC, 8'h00);
		rd_chk("f drive", PFG_IDX_F_DRIVE, 8'h00);
		wr(PFG_IDX_F_DIR, 8'hFF);
		wr(PFG_IDX_G_DIR, 8'hFF);
		rd_chk("f latch", PFG_IDX_F_DATA, 8'hFF);
		rd_chk("g latch", PFG_IDX_G_DATA, 8'hFF);
		wr(PFG_IDX_F_DIR, 8'h0F);
		wr(PFG_IDX_G_DIR, 8'hF0);
		wr(PFG_IDX_F_DATA, 8'h3C);
		wr(PFG_IDX_G_DATA, 8'hC3);
		rd_chk("f mixed", PFG_IDX_F_DATA, 8'h5C);
		rd_chk("g mixed", PFG_IDX_G_DATA, 8'hC5);
		settle;
		check("f enable", 32'(f_pins.enable), 32'h0F);
		check("f value", 32'(f_pins.value & 8'h0F), 32'h0C);
		check("g enable", 32'(g_pins.enable), 32'hF0);
		check("g value", 32'(g_pins.value & 8'hF0), 32'hC0);
		// Open drain on bits 0 and 1, bit 2 stays push-pull
		wr(PFG_IDX_F_DRIVE, 8'hFF);
		rd_chk("f drive", PFG_IDX_F_DRIVE, 8'h03);
		wr(PFG_IDX_F_DIR, 8'hFF);
		rd_chk("f latch kept", PFG_IDX_F_DATA, 8'h3C);
		wr(PFG_IDX_F_DATA, 8'h05);
		bf_en <= 8'hFC;
		settle;
		check("od enable", 32'(f_pins.enable & 8'h07), 32'h06);
		check("od value", 32'(f_pins.value & 8'h06), 32'h04);
		check("od pull up", 32'(f_level[0]), 32'h1);
		wr(PFG_IDX_F_DRIVE, 8'h00);
		bf_en <= 8'hFF;
		settle;
		check("cmos", 32'({f_pins.enable[0], f_pins.value[0]}), 32'h3);
		// Alternate functions of port F
		wr(PFG_IDX_F_DIR, 8'h55);
		bf_val <= 8'hFF;
		settle;
		check("f alt gated", 32'({sb_di, sb_in, sb_ci, req2, req3, tbclk}), 32'h0);
		wr(PFG_IDX_F_FUNC, 8'hFF);
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			bf_val <= k[0] ? 8'hAA : 8'h00;
			sb_do  <= ~k[0];
			ack2   <= ~k[0];
			sb_ck  <= k[0];
			ack3   <= k[0];
			settle;
			check("f alt enable", 32'(f_pins.enable), 32'h55);
			check("f alt out", 32'(f_pins.value & 8'h55), k[0] ? 32'h44 : 32'h11);
			check("f alt in", 32'({sb_di, sb_in, sb_ci, req2, req3, tbclk}), k[0] ? 32'h1F : 32'h20);
		end
		ack2 <= 1'b1;
		ack3 <= 1'b0;
		settle;
		check("j ack blocked", 32'(pj_ack), 32'h0);
		wr(PFG_IDX_F_FUNC, 8'h00);
		pj_req <= 2'h3;
		pj_sel <= 2'h1;
		settle;
		check("j dma", 32'({req3, req2, pj_ack}), 32'h5);
		// Port G capture and compare
		wr(PFG_IDX_G_FUNC, 8'hFF);
		bg_val <= 8'h0A;
		settle;
		check("capture", 32'(capture), 32'hA);
		check("compare", 32'(g_pins.value[7:4]), 32'h6);
		wr(PFG_IDX_G_FUNC, 8'h00);
		settle;
		check("capture off", 32'(capture), 32'h0);
		check("compare off", 32'(g_pins.value[7:4]), 32'hC);
		wr(32'h0000_0062, 8'hFF);
		rd_chk("unmapped", 32'h0000_0062, 8'h00);
		// Reset in mid-run
		@(posedge clock);
		resetn <= 1'b0;
		settle;
		check("reset enable", 32'({f_pins.enable, g_pins.enable}), 32'h0);
		@(posedge clock);
		resetn <= 1'b1;
		rd_chk("g dir again", PFG_IDX_G_DIR, 8'h00);
		wr(PFG_IDX_G_DIR, 8'hFF);
		rd_chk("g latch again", PFG_IDX_G_DATA, 8'hFF);
		complete_run;
	end
endmodule
